// file: serial_status_pkg.sv
// constants for the serial status flag block
package serial_status_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_DATA    = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  // status bit positions
  localparam int TX_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int TC_BIT   = 6;
  localparam int RX_BUFFER_FULL_FLAG_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int OR_BIT   = 3;
  localparam int NF_BIT   = 2;
  localparam int FE_BIT   = 1;
  localparam int PF_BIT   = 0;
  localparam logic [7:0] RX_FLAG_MASK = 8'h3f;
  localparam logic [7:0] TX_FLAG_MASK = 8'hc0;
  // control bit positions
  localparam int CHAR_NINE_BIT  = 0;
  localparam int IDLE_TYPE_BIT  = 1;
  localparam int PARITY_ON_BIT  = 2;
  localparam int PARITY_ODD_BIT = 3;
  localparam int TX_ON_BIT      = 4;
  localparam int BREAK_BIT      = 5;
  localparam int LONG_BRK_BIT   = 6;
  // values after reset
  localparam logic [7:0] STATUS_RESET  = 8'hc0;
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  // bit-sampling timing
  localparam int SYS_CLK_HZ    = 10_000_000;
  localparam int BAUD_HZ       = 9600;
  localparam int RT_PER_BIT    = 16;
  localparam logic [7:0] RT_DIV = 8'((SYS_CLK_HZ + BAUD_HZ * RT_PER_BIT / 2)
                                     / (BAUD_HZ * RT_PER_BIT));
  localparam logic [3:0] RT_START_FIRST = 4'h4;
  localparam logic [3:0] RT_START_LAST  = 4'ha;
  localparam logic [3:0] RT_DATA_FIRST  = 4'h8;
  localparam logic [3:0] RT_DATA_LAST   = 4'ha;
  localparam logic [3:0] RT_BIT_END     = 4'hf;
  localparam logic [2:0] START_SAMPLES  = 3'h7;
  // idle character times in sample ticks
  localparam logic [7:0] IDLE_TICKS_8  = 8'd160;
  localparam logic [7:0] IDLE_TICKS_9  = 8'd176;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  typedef enum logic [1:0] {SEL_STATUS, SEL_DATA, SEL_CONTROL, SEL_NONE} reg_sel_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : serial_status_pkg

// file: serial_status_flag_logic.sv
// status flag logic of an asynchronous serial port with an axi4-lite register slave
// Contract
// RL1 - status register read-only, writes ignored
// RL2 - tx empty set at reset, shifter load
// RL3 - status read then data write clears tx empty
// RL4 - tx complete set when buffer empty, idle
// RL5 - tx complete cleared by write, enable, break
// RL6 - rx full set when character moves in
// RL7 - status read then data read clears rx full
// RL8 - idle set after one character time high
// RL9 - idle type 0 counts from start bit
// RL10 - idle type 1 counts after stop bit
// RL11 - status read then data read clears idle
// RL12 - idle sets once per received character
// RL13 - overrun sets, new character discarded
// RL14 - status read then data read clears overrun
// RL15 - seven start samples, three per bit, noise
// RL16 - status read then data read clears noise
// RL17 - framing error when stop bit low
// RL18 - status read then data read clears framing
// RL19 - parity error on mismatch when enabled
// RL20 - status read then data read clears parity
// RL21 - long break detect blocks framing, rx full
// RL22 - character length selects eight or nine bits
// RL23 - only flags seen set are armed, cleared
`timescale 1ns/100ps
module serial_status_flag_logic (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxd,
  output logic [8:0]       tx_data,
  output logic             tx_data_valid,
  input  wire logic        tx_take,
  input  wire logic        tx_busy,
  output logic             tx_enable,
  output logic             tx_send_break,
  output logic             tx_queue_preamble
);
  import serial_status_pkg::*;

  function automatic reg_sel_t decode(input logic [3:0] addr);
    case (addr)
      OFS_STATUS:  decode = SEL_STATUS;
      OFS_DATA:    decode = SEL_DATA;
      OFS_CONTROL: decode = SEL_CONTROL;
      default:     decode = SEL_NONE;
    endcase
  endfunction : decode

  logic [7:0] status;
  logic [7:0] armed;
  logic [6:0] control;
  logic [8:0] rx_hold;
  logic       aw_got;
  logic       w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       rd_fire;
  reg_sel_t   wr_sel;
  reg_sel_t   rd_sel;
  logic       data_wr;
  logic       data_rd;
  logic       status_rd;
  logic       ctrl_wr;
  logic       tc_clear_evt;

  // write channel: address and data taken in either order, answer after both
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign wr_sel  = decode(aw_addr);
  assign data_wr = wr_fire && wr_sel == SEL_DATA && w_strb[0];
  assign ctrl_wr = wr_fire && wr_sel == SEL_CONTROL && w_strb[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // the status register accepts the write and keeps every flag
        s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY; // RL1
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: the read takes effect at the address handshake
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign rd_sel    = decode(s_axi_araddr);
  assign data_rd   = rd_fire && rd_sel == SEL_DATA;
  assign status_rd = rd_fire && rd_sel == SEL_STATUS;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rd_sel)
        SEL_STATUS:  s_axi_rdata <= {24'h0, status};
        SEL_DATA:    s_axi_rdata <= {23'h0, rx_hold};
        SEL_CONTROL: s_axi_rdata <= {25'h0, control};
        default:     s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control register and transmitter side outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control           <= CONTROL_RESET;
      tx_queue_preamble <= 1'b0;
    end else begin
      tx_queue_preamble <= ctrl_wr && w_data[TX_ON_BIT] && !control[TX_ON_BIT];
      if (ctrl_wr)
        control <= w_data[6:0];
    end
  end
  assign tx_enable     = control[TX_ON_BIT];
  assign tx_send_break = control[BREAK_BIT];

  assign tc_clear_evt = data_wr ||
                        (ctrl_wr && w_data[TX_ON_BIT] && !control[TX_ON_BIT]) ||
                        (ctrl_wr && w_data[BREAK_BIT]); // RL5

  // transmit buffer toward the shifter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_data       <= 9'h0;
      tx_data_valid <= 1'b0;
    end else if (data_wr) begin
      tx_data       <= {w_strb[1] & w_data[8], w_data[7:0]};
      tx_data_valid <= 1'b1;
    end else if (tx_take) begin
      tx_data_valid <= 1'b0;
    end
  end

  // clear sequence arming: a status read arms exactly the flags it showed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed <= 8'h0;
    end else if (status_rd) begin
      armed <= status; // RL23
    end else begin
      if (data_rd)
        armed <= armed & ~RX_FLAG_MASK;
      if (data_wr)
        armed <= armed & ~TX_FLAG_MASK & (data_rd ? ~RX_FLAG_MASK : 8'hff);
    end
  end

  // transmit empty and complete flags; a set in the clearing cycle wins for tx empty, a clear wins for tx complete
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status[TX_BUFFER_EMPTY_FLAG_BIT] <= STATUS_RESET[TX_BUFFER_EMPTY_FLAG_BIT]; // RL2
      status[TC_BIT]   <= STATUS_RESET[TC_BIT];   // RL4
    end else begin
      if (tx_take)
        status[TX_BUFFER_EMPTY_FLAG_BIT] <= 1'b1; // RL2
      else if (data_wr && armed[TX_BUFFER_EMPTY_FLAG_BIT])
        status[TX_BUFFER_EMPTY_FLAG_BIT] <= 1'b0; // RL3
      if (status[TX_BUFFER_EMPTY_FLAG_BIT] && !tx_busy && !tx_data_valid && !tx_queue_preamble
          && !control[BREAK_BIT] && !tc_clear_evt)
        status[TC_BIT] <= 1'b1; // RL4
      else if (tx_busy)
        status[TC_BIT] <= 1'b0; // RL4
      else if (tc_clear_evt && armed[TC_BIT])
        status[TC_BIT] <= 1'b0; // RL5
    end
  end

  // receive line: three stages, a level counts once stages two and three agree
  logic [2:0] rx_sync;
  logic       rx_line;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_sync <= 3'h7;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rxd};
      if (rx_sync[1] == rx_sync[2])
        rx_line <= rx_sync[2];
    end
  end

  // sample tick enable
  logic [7:0] div_cnt;
  logic       tick;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 8'h0;
      tick    <= 1'b0;
    end else begin
      tick <= (div_cnt == RT_DIV - 8'h1);
      if (div_cnt == RT_DIV - 8'h1)
        div_cnt <= 8'h0;
      else
        div_cnt <= div_cnt + 8'h1;
    end
  end

  // receiver frame sequencing with majority sampling
  rx_state_t  rx_state;
  logic [3:0] rt;
  logic [3:0] bit_idx;
  logic [2:0] ones;
  logic [2:0] ones_now;
  logic       noisy;
  logic [8:0] rx_bits;
  logic       char_done;
  logic       stop_bad;
  logic       char_noisy;
  logic [3:0] nbits;
  logic       in_window;
  logic       bit_val;
  logic       bit_noise;

  assign nbits     = control[CHAR_NINE_BIT] ? BITS_9 : BITS_8; // RL22
  assign in_window = (rx_state == RX_START) ? (rt >= RT_START_FIRST && rt <= RT_START_LAST)
                                            : (rt >= RT_DATA_FIRST && rt <= RT_DATA_LAST);
  assign ones_now  = ones + {2'h0, rx_line};
  assign bit_val   = ones_now >= 3'h2;
  assign bit_noise = ones_now != 3'h0 && ones_now != 3'h3; // RL15

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state   <= RX_IDLE;
      rt         <= 4'h0;
      bit_idx    <= 4'h0;
      ones       <= 3'h0;
      noisy      <= 1'b0;
      rx_bits    <= 9'h0;
      char_done  <= 1'b0;
      stop_bad   <= 1'b0;
      char_noisy <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (tick) begin
        rt <= rt + 4'h1;
        if (in_window && rx_state != RX_IDLE)
          ones <= ones_now;
        case (rx_state)
          RX_IDLE: begin
            rt <= 4'h0;
            if (!rx_line) begin
              rx_state <= RX_START;
              ones     <= 3'h0;
              noisy    <= 1'b0;
              rx_bits  <= 9'h0;
            end
          end
          RX_START: begin
            if (rt == RT_START_LAST) begin
              ones <= 3'h0;
              // seven start samples; a mostly high start bit is a false start
              if (ones_now > 3'h3) begin
                rx_state <= RX_IDLE;
              end else begin
                noisy <= ones_now != 3'h0; // RL15
              end
            end
            if (rt == RT_BIT_END) begin
              rx_state <= RX_DATA;
              bit_idx  <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rt == RT_DATA_LAST) begin
              rx_bits[bit_idx] <= bit_val;
              noisy            <= noisy | bit_noise; // RL15
              ones             <= 3'h0;
            end
            if (rt == RT_BIT_END) begin
              if (bit_idx == nbits - 4'h1)
                rx_state <= RX_STOP;
              bit_idx <= bit_idx + 4'h1;
            end
          end
          RX_STOP: begin
            if (rt == RT_DATA_LAST) begin
              char_done  <= 1'b1;
              stop_bad   <= !bit_val; // RL17
              char_noisy <= noisy | bit_noise;
              ones       <= 3'h0;
              rx_state   <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // parity over data and parity bit: even expects zero, odd expects one
  logic [8:0] par_mask;
  logic       par_bad;
  assign par_mask = control[CHAR_NINE_BIT] ? 9'h1ff : 9'h0ff;
  assign par_bad  = control[PARITY_ON_BIT] &&
                    ((^(rx_bits & par_mask)) != control[PARITY_ODD_BIT]); // RL19

  // receive flags and data register
  logic rx_load;
  logic rx_lost;
  assign rx_load = char_done && !control[LONG_BRK_BIT] && !status[RX_BUFFER_FULL_FLAG_BIT]; // RL21
  assign rx_lost = char_done && !control[LONG_BRK_BIT] && status[RX_BUFFER_FULL_FLAG_BIT];  // RL13

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_hold          <= 9'h0;
      status[RX_BUFFER_FULL_FLAG_BIT] <= 1'b0;
      status[NF_BIT]   <= 1'b0;
      status[FE_BIT]   <= 1'b0;
      status[PF_BIT]   <= 1'b0;
    end else if (rx_load) begin
      rx_hold          <= rx_bits & par_mask;
      status[RX_BUFFER_FULL_FLAG_BIT] <= 1'b1;       // RL6
      status[NF_BIT]   <= char_noisy; // RL15
      status[FE_BIT]   <= stop_bad;   // RL17
      status[PF_BIT]   <= par_bad;    // RL19
    end else if (data_rd) begin
      if (armed[RX_BUFFER_FULL_FLAG_BIT])
        status[RX_BUFFER_FULL_FLAG_BIT] <= 1'b0; // RL7
      if (armed[NF_BIT])
        status[NF_BIT] <= 1'b0;   // RL16
      if (armed[FE_BIT])
        status[FE_BIT] <= 1'b0;   // RL18
      if (armed[PF_BIT])
        status[PF_BIT] <= 1'b0;   // RL20
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status[OR_BIT] <= 1'b0;
    end else if (rx_lost) begin
      status[OR_BIT] <= 1'b1; // RL13
    end else if (data_rd && armed[OR_BIT]) begin
      status[OR_BIT] <= 1'b0; // RL14
    end
  end

  // idle line detection
  logic [7:0] idle_cnt;
  logic       idle_armed;
  logic       idle_hit;
  logic       idle_run;
  assign idle_run = control[IDLE_TYPE_BIT] ? (rx_state == RX_IDLE)   // RL10
                                           : (rx_state != RX_START); // RL9
  assign idle_hit = idle_cnt == (control[CHAR_NINE_BIT] ? IDLE_TICKS_9 : IDLE_TICKS_8); // RL8

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 8'h0;
    end else if (tick) begin
      if (!rx_line || !idle_run)
        idle_cnt <= 8'h0;
      else if (!idle_hit)
        idle_cnt <= idle_cnt + 8'h1; // RL9
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_armed       <= 1'b0;
      status[IDLE_BIT] <= 1'b0;
    end else begin
      if (rx_load)
        idle_armed <= 1'b1; // RL12
      else if (idle_hit && idle_armed)
        idle_armed <= 1'b0; // RL12
      if (idle_hit && idle_armed)
        status[IDLE_BIT] <= 1'b1; // RL8
      else if (data_rd && armed[IDLE_BIT])
        status[IDLE_BIT] <= 1'b0; // RL11
    end
  end
endmodule : serial_status_flag_logic

// file: serial_status_flag_logic_assertions.sv
// port checker for the serial status flag block
`timescale 1ns/100ps
module serial_status_flag_logic_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_data_valid,
  input wire logic        tx_take,
  input wire logic        tx_enable,
  input wire logic        tx_queue_preamble
);
  import serial_status_pkg::*;
  localparam logic [3:0] OFS_UNMAPPED = 4'hc;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_UNMAPPED
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  status_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS
    |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("status read malformed");
  take_frees_a: assert property (tx_take |=> !tx_data_valid)
    else $error("buffer still full after take");
  preamble_once_a: assert property (tx_queue_preamble |-> tx_enable ##1 !tx_queue_preamble)
    else $error("preamble pulse malformed");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_arvalid && s_axi_arready);
  cover property (tx_take);
  cover property (tx_queue_preamble);
endmodule : serial_status_flag_logic_assertions

bind serial_status_flag_logic serial_status_flag_logic_assertions chk_u (
  .sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data_valid,
  .tx_take, .tx_enable, .tx_queue_preamble
);

// file: serial_line_partner.sv
// remote serial sender on the receive line and transmit shifter on the buffer side
`timescale 1ns/100ps
module serial_line_partner #(
  parameter int BIT_CLKS = 1040
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      rxd,
  input  wire logic tx_data_valid,
  input  wire logic tx_queue_preamble,
  input  wire logic tx_send_break,
  output logic      tx_take,
  output logic      tx_busy
);
  logic [5:0] busy_cnt;
  logic [4:0] wait_cnt;
  initial rxd = 1'b1;
  // shifter takes the buffer late, then stays busy for a while
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_take <= 1'b0;
      busy_cnt <= 6'h0;
      wait_cnt <= 5'h0;
    end else begin
      tx_take <= 1'b0;
      if (tx_data_valid && !tx_take && busy_cnt == 6'h0) begin
        wait_cnt <= wait_cnt + 5'h1;
      end
      if (wait_cnt == 5'h14) begin
        wait_cnt <= 5'h0;
        tx_take <= 1'b1;
        busy_cnt <= 6'h28;
      end else if (tx_queue_preamble) begin
        busy_cnt <= 6'h28;
      end else if (busy_cnt != 6'h0) begin
        busy_cnt <= busy_cnt - 6'h1;
      end
    end
  end
  assign tx_busy = busy_cnt != 6'h0 || tx_send_break;
  // one frame, lsb first; noisy puts a short high spike inside the start bit
  task automatic send_frame(input logic [8:0] d, input int nbits, input logic stop,
                            input logic noisy);
    int i;
    rxd <= 1'b0;
    repeat (420) @(posedge sys_clk);
    rxd <= noisy;
    repeat (100) @(posedge sys_clk);
    rxd <= 1'b0;
    repeat (BIT_CLKS - 520) @(posedge sys_clk);
    for (i = 0; i < nbits; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    rxd <= stop;
    repeat (BIT_CLKS) @(posedge sys_clk);
    rxd <= 1'b1;
  endtask : send_frame
endmodule : serial_line_partner

// file: serial_status_flag_logic_test.sv
// self-checking bench for the serial status flag block
`timescale 1ns/100ps
module serial_status_flag_logic_test;
  import serial_status_pkg::*;
  localparam int BIT_CLKS = RT_PER_BIT * int'(RT_DIV);
  localparam logic [3:0] OFS_UNMAPPED = 4'hc;
  logic        sys_clk, rst, rxd, tx_take, tx_busy;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  tx_data;
  logic        tx_data_valid, tx_enable, tx_send_break, tx_queue_preamble;
  int          errors, tests_run;

  serial_status_flag_logic dut_u (
    .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .tx_data, .tx_data_valid,
    .tx_take, .tx_busy, .tx_enable, .tx_send_break, .tx_queue_preamble
  );
  serial_line_partner #(.BIT_CLKS(BIT_CLKS)) partner_u (
    .sys_clk, .rst, .rxd, .tx_data_valid, .tx_queue_preamble, .tx_send_break,
    .tx_take, .tx_busy
  );

  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic status_is(input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_STATUS, d, r);
    chk("status", d, {24'h0, e});
  endtask : status_is

  task automatic data_is(input logic [8:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_DATA, d, r);
    chk("rx data", d, {23'h0, e});
  endtask : data_is

  task automatic ctrl(input logic [31:0] v);
    logic [1:0] r;
    wr(OFS_CONTROL, v, r);
  endtask : ctrl

  task automatic bits(input int n);
    repeat (n * BIT_CLKS) @(posedge sys_clk);
  endtask : bits

  task automatic t_regs;
    logic [1:0] r;
    status_is(8'hc0);
    wr(OFS_STATUS, 32'h0, r);
    chk("status write resp", 32'(r), 32'(RESP_OKAY));
    status_is(8'hc0);
    wr(OFS_UNMAPPED, 32'h0, r);
    chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
  endtask : t_regs

  task automatic t_tx;
    logic [1:0] r;
    status_is(8'hc0);
    wr(OFS_DATA, 32'h5a, r);
    chk("tx data", 32'(tx_data), 32'h5a);
    chk("tx buffer valid", 32'(tx_data_valid), 32'h1);
    status_is(8'h00);
    repeat (80) @(posedge sys_clk);
    status_is(8'hc0);
    ctrl(32'h10);
    status_is(8'h80);
    repeat (80) @(posedge sys_clk);
    status_is(8'hc0);
    ctrl(32'h30);
    chk("tx enable", 32'(tx_enable), 32'h1);
    chk("tx break", 32'(tx_send_break), 32'h1);
    status_is(8'h80);
    ctrl(32'h00);
    chk("tx break off", 32'(tx_send_break), 32'h0);
    repeat (80) @(posedge sys_clk);
    status_is(8'hc0);
  endtask : t_tx

  task automatic t_idle_early;
    ctrl(32'h00);
    partner_u.send_frame(9'h0ff, 8, 1'b1, 1'b0);
    bits(2);
    status_is(8'hf0);
    data_is(9'h0ff);
    status_is(8'hc0);
  endtask : t_idle_early

  task automatic t_idle_late;
    ctrl(32'h02);
    partner_u.send_frame(9'h0ff, 8, 1'b1, 1'b0);
    bits(2);
    status_is(8'he0);
    bits(9);
    status_is(8'hf0);
    data_is(9'h0ff);
    status_is(8'hc0);
  endtask : t_idle_late

  task automatic t_long_break;
    ctrl(32'h42);
    partner_u.send_frame(9'h000, 8, 1'b0, 1'b0);
    bits(11);
    status_is(8'hc0);
  endtask : t_long_break

  task automatic t_errors;
    ctrl(32'h06);
    partner_u.send_frame(9'h083, 8, 1'b0, 1'b1);
    bits(1);
    partner_u.send_frame(9'h002, 8, 1'b1, 1'b0);
    bits(1);
    status_is(8'hef);
    data_is(9'h083);
    status_is(8'hc0);
  endtask : t_errors

  task automatic t_nine;
    ctrl(32'h03);
    partner_u.send_frame(9'h1a5, 9, 1'b1, 1'b0);
    bits(1);
    status_is(8'he0);
    data_is(9'h1a5);
  endtask : t_nine

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (98000) @(posedge sys_clk);
    errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_tx();
    t_idle_early();
    t_idle_late();
    t_long_break();
    t_errors();
    t_nine();
    close_out();
  end
endmodule : serial_status_flag_logic_test
